// ===== fifo_flag_consts.svh
// Constants for the flag and read-echo block of the dual-clock FIFO.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FIFO_FLAG_CONSTS_SVH
`define FIFO_FLAG_CONSTS_SVH

// Data word width and array capacity in standard mode
`define FF_DATA_WIDTH 36
`define FF_DEPTH 16

// Reset values of the active-low outputs
`define FF_FLAG_RESET 1'b1
`define FF_ECHO_RESET 1'b1
`define FF_READY_RESET 1'b1

// Bench period of the write and read pin clocks, in ns, and system clock period in ns
`define FF_LINK_PERIOD_NS 160
`define FF_CLK_PERIOD_NS 4
`define FF_LINK_PERIOD_CYCLES ((`FF_LINK_PERIOD_NS) / (`FF_CLK_PERIOD_NS))

`endif

// ===== fifo_flag_pkg.sv
// Types for the flag and read-echo block of the dual-clock FIFO.
// Assumes the constants header sits in the same folder.
`include "fifo_flag_consts.svh"

package fifo_flag_pkg;

  typedef struct packed {
    logic clock;
    logic enableN;
    logic [`FF_DATA_WIDTH-1:0] data;
  } write_pins_s;

  typedef struct packed {
    logic clock;
    logic enableN;
    logic chipSelectN;
    logic outputEnableN;
  } read_pins_s;

  typedef struct packed {
    logic flagTimingSelect;
    logic fallThroughMode;
    logic asyncReadPort;
  } straps_s;

  // Gray sequence: capture straps, settle, run
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b11
  } mode_state_e;

endpackage : fifo_flag_pkg

// ===== fifo_flag_and_read_echo.sv
// Flag and read-side output logic of a dual-clock FIFO, plus its word buffer.
// Assumes all pins are asynchronous to clk; the pin clocks are sampled, not used as clocks.
// How it works
// - Full-side depth is buffer capacity, plus one word in fall-through mode.
// - Synchronous almost-full flag changes only on write clock rising edges.
// - Synchronous almost-full flag rises one write cycle after space is freed.
// - Synchronous almost-empty flag rises one read cycle after the qualifying write.
// - Flag timing select strap is latched after reset release: high synchronous, low asynchronous.
// - Asynchronous almost-full falls on write clock edge, rises on read clock edge.
// - Asynchronous almost-empty falls on read clock edge, rises on write clock edge.
// - Standard mode: echoed read enable is chip select AND read enable, forced high when empty.
// - Echoed read enable changes only on read clock rising edges.
// - Output bus is driven only while chip select and output enable are low.
// - Fall-through: first word loads itself, ready goes low, echo pulses low.
// - Fall-through: read past last word raises ready flag and echo.
// - Asynchronous read port timing exists only in standard mode.
`timescale 1ns/1ps
`include "fifo_flag_consts.svh"

module fifo_buffer #(
  parameter int WIDTH = `FF_DATA_WIDTH,
  parameter int DEPTH = `FF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo_buffer depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;

  assign inReady = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign count = count_q;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(doPush);
      rdPtr_q <= rdPtr_q + AW'(doPop);
      count_q <= count_q + CW'(doPush) - CW'(doPop);
    end
  end
endmodule : fifo_buffer

module fifo_flag_and_read_echo #(
  parameter int DEPTH = `FF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port pins
  input wire fifo_flag_pkg::write_pins_s writePins,
  output logic writeReadyN,
  // Read port pins
  input wire fifo_flag_pkg::read_pins_s readPins,
  output logic [`FF_DATA_WIDTH-1:0] dataOutputBus,
  output logic dataOutputEnable,
  output logic echoedReadEnableN,
  output logic outputReadyN,
  // Straps, flags and offsets
  input wire fifo_flag_pkg::straps_s straps,
  input wire logic [$clog2(DEPTH+2)-1:0] fullOffset,
  input wire logic [$clog2(DEPTH+2)-1:0] emptyOffset,
  output logic almostFullFlagN,
  output logic almostEmptyFlagN
);
  import fifo_flag_pkg::*;

  localparam int CW = $clog2(DEPTH+2);
  localparam int FCW = $clog2(DEPTH+1);
  localparam int W = `FF_DATA_WIDTH;

  generate
    if (DEPTH < 2) begin : g_bad_depth
      $error("fifo_flag_and_read_echo needs a depth of at least 2");
    end
  endgenerate

  // Two-stage synchronisers for every pin except the offsets
  write_pins_s wMeta_q, wSync_q;
  read_pins_s rMeta_q, rSync_q;
  straps_s sMeta_q, sSync_q;
  logic wClkPrev_q, rClkPrev_q, rEnPrev_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wMeta_q <= '0;
      wSync_q <= '0;
      rMeta_q <= '1;
      rSync_q <= '1;
    end else begin
      wMeta_q <= writePins;
      wSync_q <= wMeta_q;
      rMeta_q <= readPins;
      rSync_q <= rMeta_q;
    end
  end
  // Straps keep sampling through reset, so the latch after release sees them
  always_ff @(posedge clk) begin
    sMeta_q <= straps;
    sSync_q <= sMeta_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wClkPrev_q <= 1'b0;
      rClkPrev_q <= 1'b1; // Matches the synchroniser reset, no false edge
      rEnPrev_q <= 1'b1;
    end else begin
      wClkPrev_q <= wSync_q.clock;
      rClkPrev_q <= rSync_q.clock;
      rEnPrev_q <= rSync_q.enableN;
    end
  end

  wire wEdge = wSync_q.clock && !wClkPrev_q;
  wire rEdge = rSync_q.clock && !rClkPrev_q;
  wire renFall = !rSync_q.enableN && rEnPrev_q;
  wire rdEn = !rSync_q.enableN && !rSync_q.chipSelectN;

  // Straps are caught by a clocked process after reset release
  mode_state_e state_q, state_d;
  logic syncFlags_q, fall_through_mode_q, asyncRd_q;

  always_comb begin
    case (state_q)
      ST_CAPTURE: state_d = ST_SETTLE;
      ST_SETTLE: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_CAPTURE;
    endcase
  end

  wire running = (state_q == ST_RUN);
  wire latchStraps = (state_q == ST_SETTLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_CAPTURE;
      syncFlags_q <= 1'b0;
      fall_through_mode_q <= 1'b0;
      asyncRd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (latchStraps) begin
        syncFlags_q <= sSync_q.flagTimingSelect;
        fall_through_mode_q <= sSync_q.fallThroughMode;
        asyncRd_q <= sSync_q.asyncReadPort && !sSync_q.fallThroughMode;
      end
    end
  end

  // Word buffer
  logic fifoInReady, fifoHas;
  logic [W-1:0] fifoData;
  logic [FCW-1:0] fifoCount;
  logic outFull_q;

  wire push = running && wEdge && !wSync_q.enableN;
  // Async read takes the falling read enable instead of the read clock
  wire readCmd = asyncRd_q ? (renFall && !rSync_q.chipSelectN) : (rEdge && rdEn);
  wire fwftLoad = rEdge && fifoHas && (!outFull_q || rdEn);
  wire fwftDrain = rEdge && rdEn && outFull_q && !fifoHas;
  wire pop = running && (fall_through_mode_q ? fwftLoad : (readCmd && fifoHas));

  fifo_buffer #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) i_fifo_buffer (
    .clk(clk),
    .reset(reset),
    .inValid(push),
    .inReady(fifoInReady),
    .inData(wSync_q.data),
    .outValid(fifoHas),
    .outReady(pop),
    .outData(fifoData),
    .count(fifoCount)
  );

  // Level seen by the flags counts the output register in fall-through mode
  wire [CW-1:0] level = CW'(fifoCount) + CW'(fall_through_mode_q && outFull_q);
  wire [CW-1:0] maxDepth = fall_through_mode_q ? CW'(DEPTH + 1) : CW'(DEPTH);
  wire [CW-1:0] freeSpace = maxDepth - level;
  wire afCond = (freeSpace <= fullOffset);
  wire aeCond = (level <= emptyOffset);

  // Read side registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      outFull_q <= 1'b0;
      dataOutputBus <= '0;
      echoedReadEnableN <= `FF_ECHO_RESET;
      outputReadyN <= `FF_READY_RESET;
    end else begin
      if (pop) begin
        dataOutputBus <= fifoData;
      end
      if (running && fall_through_mode_q) begin
        if (pop) begin
          outFull_q <= 1'b1;
        end else if (fwftDrain) begin
          outFull_q <= 1'b0;
        end
      end
      if (running && rEdge) begin
        if (fall_through_mode_q) begin
          echoedReadEnableN <= !pop;
          outputReadyN <= !(pop || (outFull_q && !fwftDrain));
        end else begin
          echoedReadEnableN <= !(rdEn && fifoHas);
          outputReadyN <= !fifoHas;
        end
      end
    end
  end

  // Bus enable follows chip select and output enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataOutputEnable <= 1'b0;
      writeReadyN <= 1'b0;
    end else begin
      dataOutputEnable <= !rSync_q.chipSelectN && !rSync_q.outputEnableN;
      writeReadyN <= !fifoInReady;
    end
  end

  // Programmable flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      almostFullFlagN <= `FF_FLAG_RESET;
      almostEmptyFlagN <= `FF_FLAG_RESET;
    end else if (running) begin
      if (syncFlags_q) begin
        if (wEdge) begin
          almostFullFlagN <= !afCond;
        end
        if (rEdge) begin
          almostEmptyFlagN <= !aeCond;
        end
      end else begin
        if (wEdge && afCond) begin
          almostFullFlagN <= 1'b0;
        end else if (rEdge && !afCond) begin
          almostFullFlagN <= 1'b1;
        end
        if (rEdge && aeCond) begin
          almostEmptyFlagN <= 1'b0;
        end else if (wEdge && !aeCond) begin
          almostEmptyFlagN <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_af_write_edge: assert property (
    running && syncFlags_q && $changed(almostFullFlagN) |-> $past(wEdge))
    else $error("almost-full moved without a write clock edge");
  chk_af_sync_rise: assert property (
    running && syncFlags_q && wEdge && !afCond |=> almostFullFlagN)
    else $error("almost-full did not rise after space was freed");
  chk_ae_sync_rise: assert property (
    running && syncFlags_q && rEdge && !aeCond |=> almostEmptyFlagN)
    else $error("almost-empty did not rise after the write");
  chk_strap_latch: assert property (
    latchStraps |=> syncFlags_q == $past(sSync_q.flagTimingSelect))
    else $error("flag timing select not latched");
  chk_af_async_fall: assert property (
    running && !syncFlags_q && wEdge && afCond |=> !almostFullFlagN)
    else $error("async almost-full did not fall on write edge");
  chk_ae_async_fall: assert property (
    running && !syncFlags_q && rEdge && aeCond |=> !almostEmptyFlagN)
    else $error("async almost-empty did not fall on read edge");
  chk_echo_and_term: assert property (
    running && !fall_through_mode_q && rEdge |=> echoedReadEnableN == !$past(rdEn && fifoHas))
    else $error("echoed read enable wrong in standard mode");
  chk_echo_read_edge: assert property (
    running && $changed(echoedReadEnableN) |-> $past(rEdge))
    else $error("echoed read enable moved off the read clock edge");
  chk_bus_enable: assert property (
    dataOutputEnable |-> $past(!rSync_q.chipSelectN && !rSync_q.outputEnableN))
    else $error("output bus driven without select and enable");
  chk_fall_through_mode_fall_through: assert property (
    running && fall_through_mode_q && rEdge && !outFull_q && fifoHas
    |=> !outputReadyN && !echoedReadEnableN ##1 outFull_q)
    else $error("first word did not fall through");
  chk_fall_through_mode_drain: assert property (
    running && fall_through_mode_q && fwftDrain |=> outputReadyN && echoedReadEnableN && !outFull_q)
    else $error("read past last word did not raise ready and echo");
  chk_async_std_only: assert property (
    fall_through_mode_q |-> !asyncRd_q)
    else $error("async read enabled in fall-through mode");
  chk_level_bound: assert property (
    running |-> level <= maxDepth)
    else $error("stored level beyond maximum depth");

endmodule : fifo_flag_and_read_echo

// ===== link_partner.sv
// Far-side model: writer and reader controllers, each on its own pin clock.
// Assumes the block samples every pin with its own clk.
`timescale 1ns/1ps
`include "fifo_flag_consts.svh"
module link_partner (
  // Pins toward the block
  output fifo_flag_pkg::write_pins_s writePins,
  output fifo_flag_pkg::read_pins_s readPins
);
  import fifo_flag_pkg::*;
  logic wClk;
  logic rClk;
  logic wEnN;
  logic rEnN;
  logic csN;
  logic oeN;
  logic [`FF_DATA_WIDTH-1:0] wData;
  assign writePins = {wClk, wEnN, wData};
  assign readPins = {rClk, rEnN, csN, oeN};
  // Free-running pin clocks, phase unrelated to clk
  initial begin
    wClk = 1'h0;
    #1.3;
    forever #80 wClk = ~wClk;
  end
  initial begin
    rClk = 1'h0;
    #51.7;
    forever #80 rClk = ~rClk;
  end
  initial begin
    wEnN = 1'h1;
    rEnN = 1'h1;
    csN = 1'h1;
    oeN = 1'h0;
    wData = '0;
  end
  // Pins move on falling pin edges, far from the sampled rising edge
  task automatic put(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(negedge wClk);
      wEnN <= 1'h0;
      wData <= 36'(base + i);
    end
    @(negedge wClk);
    wEnN <= 1'h1;
    // Released data is stale, so it toggles rather than holding
    wData <= ~wData;
  endtask : put
  task automatic get(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge rClk);
      rEnN <= 1'h0;
    end
    @(negedge rClk);
    rEnN <= 1'h1;
  endtask : get
  task automatic select(input logic cs, input logic oe);
    @(negedge rClk);
    csN <= cs;
    oeN <= oe;
  endtask : select
endmodule : link_partner

// ===== tb_fifo_flag_and_read_echo.sv
// Self-checking bench for the flag and read-echo block.
// Assumes the far-side model drives the write and read pins; clk runs at 250 MHz.
`timescale 1ns/1ps
`include "fifo_flag_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errorCnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_fifo_flag_and_read_echo;
  import fifo_flag_pkg::*;
  typedef struct {int lvl; logic aeN; logic afN; logic wrN;} row_s;
  logic clk;
  logic reset;
  straps_s straps;
  logic [4:0] fullOffset;
  logic [4:0] emptyOffset;
  write_pins_s writePins;
  read_pins_s readPins;
  logic writeReadyN;
  logic [`FF_DATA_WIDTH-1:0] dataOutputBus;
  logic dataOutputEnable;
  logic echoedReadEnableN;
  logic outputReadyN;
  logic almostFullFlagN;
  logic almostEmptyFlagN;
  int errorCnt;
  int checks;
  int cur;
  // Fill levels with empty offset 2, full offset 3, depth 16
  row_s rows[6] = '{'{1, 0, 1, 0}, '{2, 0, 1, 0}, '{3, 1, 1, 0}, '{12, 1, 1, 0},
                    '{13, 1, 0, 0}, '{16, 1, 0, 1}};

  fifo_flag_and_read_echo #(.DEPTH(16)) i_fifo_flag_and_read_echo (
    .clk(clk), .reset(reset), .writePins(writePins), .writeReadyN(writeReadyN),
    .readPins(readPins), .dataOutputBus(dataOutputBus), .dataOutputEnable(dataOutputEnable),
    .echoedReadEnableN(echoedReadEnableN), .outputReadyN(outputReadyN), .straps(straps),
    .fullOffset(fullOffset), .emptyOffset(emptyOffset), .almostFullFlagN(almostFullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN));
  link_partner i_link_partner (.writePins(writePins), .readPins(readPins));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic settle;
    repeat (2) @(posedge writePins.clock);
    repeat (2) @(posedge readPins.clock);
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic startUp(input logic sync, input logic fall_through_mode, input logic asyncRd);
    @(posedge clk);
    reset <= 1'h1;
    straps <= '{sync, fall_through_mode, asyncRd};
    repeat (12) @(posedge clk);
    `CHK("resetFlags", 2'h3, {almostFullFlagN, almostEmptyFlagN})
    `CHK("resetEcho", 2'h3, {echoedReadEnableN, outputReadyN})
    `CHK("resetWrite", 2'h0, {writeReadyN, dataOutputEnable})
    reset <= 1'h0;
    repeat (12) @(posedge clk);
  endtask : startUp

  task automatic results;
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    reset = 1'h1;
    straps = '0;
    fullOffset = 5'h03;
    emptyOffset = 5'h02;
    errorCnt = 0;
    checks = 0;
    cur = 0;
    startUp(1'h1, 1'h0, 1'h0);
    foreach (rows[k]) begin
      i_link_partner.put(rows[k].lvl - cur, cur);
      cur = rows[k].lvl;
      settle();
      `CHK("almostEmpty", rows[k].aeN, almostEmptyFlagN)
      `CHK("almostFull", rows[k].afN, almostFullFlagN)
      `CHK("writeReady", rows[k].wrN, writeReadyN)
    end
    // Write into a full buffer must be dropped
    i_link_partner.put(1, 32'h0000_0063);
    settle();
    `CHK("fullRefuse", 1'h1, writeReadyN)
    i_link_partner.select(1'h0, 1'h0);
    settle();
    `CHK("busEnable", 1'h1, dataOutputEnable)
    for (int i = 0; i < 16; i++) begin
      i_link_partner.get(1);
      `CHK("readData", 36'(i), dataOutputBus)
      if (i < 15) `CHK("echoLow", 1'h0, echoedReadEnableN)
      if (i == 3) begin
        settle();
        `CHK("afRelease", 1'h1, almostFullFlagN)
      end
    end
    settle();
    // Standard mode: the ready flag is high once the buffer has run dry
    `CHK("emptyFlag", 1'h1, outputReadyN)
    `CHK("aeLow", 1'h0, almostEmptyFlagN)
    i_link_partner.get(1);
    settle();
    `CHK("echoEmpty", 1'h1, echoedReadEnableN)
    `CHK("dataHold", 36'h0_0000_000f, dataOutputBus)
    i_link_partner.select(1'h0, 1'h1);
    settle();
    `CHK("oeHigh", 1'h0, dataOutputEnable)
    // Fall-through with asynchronous flags
    fullOffset <= 5'h0f;
    emptyOffset <= 5'h00;
    startUp(1'h0, 1'h1, 1'h1);
    i_link_partner.select(1'h1, 1'h0);
    settle();
    `CHK("aeAsyncLow", 1'h0, almostEmptyFlagN)
    `CHK("afAsyncHigh", 1'h1, almostFullFlagN)
    i_link_partner.put(1, 32'h0000_005a);
    for (int t = 0; t < 400 && outputReadyN !== 1'h0; t++) @(negedge clk);
    `CHK("fallReady", 1'h0, outputReadyN)
    `CHK("fallEcho", 1'h0, echoedReadEnableN)
    `CHK("csHighBus", 1'h0, dataOutputEnable)
    @(posedge readPins.clock);
    repeat (8) @(posedge clk);
    `CHK("echoBack", 1'h1, echoedReadEnableN)
    // Async flags only rise on the next owning edge, which has now passed
    `CHK("aeAsyncRise", 1'h1, almostEmptyFlagN)
    `CHK("afDepth", 1'h1, almostFullFlagN)
    i_link_partner.put(1, 32'h0000_005b);
    settle();
    `CHK("afAsyncFall", 1'h0, almostFullFlagN)
    i_link_partner.select(1'h0, 1'h0);
    @(posedge readPins.clock);
    settle();
    `CHK("fallData", 36'h0_0000_005a, dataOutputBus)
    `CHK("fallBusOn", 1'h1, dataOutputEnable)
    i_link_partner.get(1);
    settle();
    `CHK("nextData", 36'h0_0000_005b, dataOutputBus)
    `CHK("afAsyncRise", 1'h1, almostFullFlagN)
    i_link_partner.get(1);
    settle();
    `CHK("lastReady", 1'h1, outputReadyN)
    `CHK("lastEcho", 1'h1, echoedReadEnableN)
    `CHK("aeAsyncFall", 1'h0, almostEmptyFlagN)
    // Standard mode, async read: enable held low over two read edges pops once
    startUp(1'h1, 1'h0, 1'h1);
    i_link_partner.put(2, 32'h0000_0030);
    settle();
    i_link_partner.get(2);
    `CHK("asyncOnce", 36'h0_0000_0030, dataOutputBus)
    i_link_partner.get(1);
    `CHK("asyncNext", 36'h0_0000_0031, dataOutputBus)
    results();
  end

  initial begin
    #100000;
    errorCnt++;
    results();
  end
endmodule : tb_fifo_flag_and_read_echo
